// *** adcc_pkg.sv ***
// Shared constants, state type and decode helpers for the converter sequencer
package adcc_pkg;
   // Conversion clock select codes
   localparam logic [1:0] CS_2TOSC = 2'h0;
   localparam logic [1:0] CS_8TOSC = 2'h1;
   localparam logic [1:0] CS_32TOSC = 2'h2;
   localparam logic [1:0] CS_RC = 2'h3;
   // Half bit period in oscillator periods for each divisor
   localparam logic [4:0] HALF_2TOSC = 5'h01;
   localparam logic [4:0] HALF_8TOSC = 5'h04;
   localparam logic [4:0] HALF_32TOSC = 5'h10;
   // Compare unit special trigger mode
   localparam logic [3:0] CMP_SPECIAL_TRIGGER = 4'hB;
   localparam int RESULT_W = 8;
   localparam logic [RESULT_W-1:0] SAR_TOP_BIT = 8'h80;
   localparam logic [2:0] SAR_TOP_IDX = 3'h7;
   // Sequence lengths in half bit periods: 9.5 periods per conversion
   localparam logic [4:0] CONV_HALVES = 5'h13;
   localparam logic [4:0] SETUP_HALVES = 5'h03;
   // Capacitor stays disconnected for two bit periods after a conversion
   localparam logic [4:0] HOLD_HALVES = 5'h04;
   // Clock and instruction cycle timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int INSTR_CYCLE_NS = 400;
   localparam logic [2:0] INSTR_CYCLES = 3'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_RCWAIT, ST_CONV, ST_HOLD, ST_PWRDN} adcc_state_t;

   function automatic logic adcc_is_rc(input logic [1:0] sel);
      adcc_is_rc = (sel == CS_RC);
   endfunction

   function automatic logic [4:0] adcc_half_period(input logic [1:0] sel);
      case (sel)
         CS_2TOSC: adcc_half_period = HALF_2TOSC;
         CS_8TOSC: adcc_half_period = HALF_8TOSC;
         default: adcc_half_period = HALF_32TOSC;
      endcase
   endfunction

   function automatic logic adcc_busy(input adcc_state_t st);
      adcc_busy = (st == ST_CONV) || (st == ST_RCWAIT);
   endfunction
endpackage

// *** adcc_tad_gen.sv ***
// Half bit period enable generator for the conversion clock
`timescale 1ns/1ps
module adcc_tad_gen
   import adcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [1:0] clk_sel,
   input wire logic rc_half_tick,
   output logic half_tick
);
   logic [4:0] cnt_r;

   // Divider follows the live select so a mid-conversion switch takes effect at once
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_r <= 5'h00;
         half_tick <= 1'b0;
      end else if (adcc_is_rc(clk_sel)) begin
         cnt_r <= 5'h00;
         half_tick <= rc_half_tick;
      end else if (cnt_r >= adcc_half_period(clk_sel) - 5'h01) begin
         // >= so a switch to a shorter divisor never lets the count run away
         cnt_r <= 5'h00;
         half_tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         half_tick <= 1'b0;
      end
   end
endmodule

// *** adcc_sar.sv ***
// Successive approximation register, one decision per step
`timescale 1ns/1ps
module adcc_sar
   import adcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic step,
   input wire logic cmp_in,
   output logic [RESULT_W-1:0] bits,
   output logic [RESULT_W-1:0] trial
);
   logic [RESULT_W-1:0] mask_r;
   logic [2:0] idx_r;

   // Decided bits plus the bit now under trial drive the comparator DAC
   assign trial = bits | mask_r;

   // Load clears the code; each step keeps or drops the trial bit
   always_ff @(posedge clk) begin
      if (rst || load) begin
         bits <= '0;
         mask_r <= SAR_TOP_BIT;
         idx_r <= SAR_TOP_IDX;
      end else if (step) begin
         bits[idx_r] <= cmp_in;
         mask_r <= mask_r >> 1;
         idx_r <= idx_r - 3'h1;
      end
   end
endmodule

// *** adcc_ctrl.sv ***
// Conversion control sequencer for the 8-bit converter
// Operation
// - Abort via go/done clear keeps last completed or software-written result.
// - After abort wait two bit periods, then acquire selected channel automatically.
// - Completion clears go/done and stores the new 8-bit result.
// - Acquisition time is the same whatever resolution is intended.
// - Clock may switch mid-conversion only among oscillator divisors, never RC.
// - With RC clock, wait one instruction cycle after start before converting.
// - Completion in sleep with RC clock and interrupt enabled wakes processor.
// - Completion in sleep, RC, interrupt disabled powers down; on bit stays set.
// - Sleep with oscillator clock aborts conversion and powers down; on stays set.
// - Any reset restores control values, switches off, aborts conversion.
// - Power-on reset leaves the result register uninitialised.
// - Compare trigger in mode 1011 with converter on starts conversion, clears timer.
// - With converter off, trigger starts nothing but still clears timer.
// - A full conversion takes nine and a half bit periods.
// - Select field picks 2, 8, 32 oscillator periods or RC per bit.
// - Completion also sets the conversion done flag.
// - After completion capacitor stays disconnected two bit periods before acquiring.
`timescale 1ns/1ps
module adcc_ctrl
   import adcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_ctrl,
   input wire logic wr_on,
   input wire logic wr_go,
   input wire logic [1:0] wr_clk_sel,
   input wire logic wr_result,
   input wire logic [RESULT_W-1:0] wr_result_data,
   input wire logic clr_done_flag,
   input wire logic conversion_irq_enable,
   input wire logic sleep,
   input wire logic [3:0] compare_mode_select,
   input wire logic compare_event,
   input wire logic rc_half_tick,
   input wire logic cmp_in,
   output logic converter_on,
   output logic go_done,
   output logic [1:0] conversion_clock_select,
   output logic [RESULT_W-1:0] conversion_result,
   output logic conversion_done_flag,
   output logic wake_request,
   output logic timer_clear,
   output logic converter_powered,
   output logic sample_connect,
   output logic [RESULT_W-1:0] sar_trial
);
   adcc_state_t st_r;
   logic [4:0] half_r;
   logic [4:0] half_nxt;
   logic [2:0] wait_r;
   logic on_r;
   logic go_r;
   logic flag_r;
   logic wake_r;
   logic tclr_r;
   logic [1:0] sel_r;
   logic [RESULT_W-1:0] result_r;
   logic half_tick;
   logic run_tad;
   logic [RESULT_W-1:0] sar_bits;
   logic special;
   logic trig_start;
   logic sw_start;
   logic go_set;
   logic go_kill;
   logic off_req;
   logic abort_req;
   logic osc_sleep_abort;
   logic conv_done;
   logic sar_step;
   logic sel_ok;

   // Bit clock runs through conversion and the post-conversion hold
   assign run_tad = (st_r == ST_CONV) || (st_r == ST_HOLD);
   assign half_nxt = half_r + 5'h01;

   // Request decode
   assign special = compare_event && (compare_mode_select == CMP_SPECIAL_TRIGGER);
   assign trig_start = special && on_r;
   assign sw_start = wr_ctrl && wr_go && wr_on;
   assign go_set = sw_start || trig_start;
   assign off_req = wr_ctrl && !wr_on;
   assign abort_req = wr_ctrl && !wr_go && adcc_busy(st_r);
   // Oscillator clocks stop in sleep, so anything in flight is lost
   assign osc_sleep_abort = sleep && !adcc_is_rc(sel_r) && on_r && (st_r != ST_OFF) && (st_r != ST_PWRDN);
   assign go_kill = off_req || (!on_r && !sw_start) || osc_sleep_abort;
   assign conv_done = (st_r == ST_CONV) && half_tick && (half_nxt == CONV_HALVES) && !wr_ctrl
      && !osc_sleep_abort;
   // Decisions at half periods 4, 6 ... 18 after 1.5 periods of setup
   assign sar_step = (st_r == ST_CONV) && half_tick && (half_nxt > SETUP_HALVES) && !half_nxt[0]
      && (half_nxt < CONV_HALVES);
   // Switching to or from RC while busy would glitch the bit clock
   assign sel_ok = !adcc_busy(st_r) || (!adcc_is_rc(sel_r) && !adcc_is_rc(wr_clk_sel));

   adcc_tad_gen u_tad (
      .clk(clk),
      .rst(rst),
      .run(run_tad),
      .clk_sel(sel_r),
      .rc_half_tick(rc_half_tick),
      .half_tick(half_tick)
   );

   adcc_sar u_sar (
      .clk(clk),
      .rst(rst),
      .load(st_r != ST_CONV),
      .step(sar_step),
      .cmp_in(cmp_in),
      .bits(sar_bits),
      .trial(sar_trial)
   );

   // Sequencer; later overrides take priority: off over sleep over abort
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= ST_OFF;
         half_r <= 5'h00;
         wait_r <= 3'h0;
      end else begin
         case (st_r)
            ST_OFF: begin
               if (on_r) begin
                  st_r <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               // Acquisition length is set by the start request (software write or compare trigger), not by resolution
               if (go_r) begin
                  half_r <= 5'h00;
                  wait_r <= 3'h0;
                  st_r <= adcc_is_rc(sel_r) ? ST_RCWAIT : ST_CONV;
               end
            end
            ST_RCWAIT: begin
               // Gives the sleep instruction time to quiet digital noise
               wait_r <= wait_r + 3'h1;
               if (wait_r == INSTR_CYCLES - 3'h1) begin
                  st_r <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (half_tick) begin
                  half_r <= half_nxt;
               end
               if (conv_done) begin
                  half_r <= 5'h00;
                  st_r <= (sleep && !conversion_irq_enable) ? ST_PWRDN : ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (half_tick) begin
                  half_r <= half_nxt;
               end
               if (half_tick && (half_nxt == HOLD_HALVES)) begin
                  st_r <= ST_ACQ;
               end
            end
            ST_PWRDN: begin
               if (!sleep) begin
                  half_r <= 5'h00;
                  st_r <= ST_HOLD;
               end
            end
            default: st_r <= ST_OFF;
         endcase
         if (abort_req) begin
            half_r <= 5'h00;
            st_r <= ST_HOLD;
         end
         if (osc_sleep_abort) begin
            st_r <= ST_PWRDN;
         end
         if (!on_r || off_req) begin
            st_r <= ST_OFF;
         end
      end
   end

   // Converter on bit and clock select
   always_ff @(posedge clk) begin
      if (rst) begin
         on_r <= 1'b0;
         sel_r <= CS_2TOSC;
      end else if (wr_ctrl) begin
         on_r <= wr_on;
         if (sel_ok) begin
            sel_r <= wr_clk_sel;
         end
      end
   end

   // Go/done: a new start beats a completion in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         go_r <= 1'b0;
      end else if (go_kill) begin
         go_r <= 1'b0;
      end else if (go_set) begin
         go_r <= 1'b1;
      end else if (conv_done || (wr_ctrl && !wr_go)) begin
         go_r <= 1'b0;
      end
   end

   // Result has no reset: contents survive every reset
   always_ff @(posedge clk) begin
      if (conv_done) begin
         result_r <= sar_bits;
      end else if (wr_result) begin
         result_r <= wr_result_data;
      end
   end

   // Done flag, set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (conv_done) begin
         flag_r <= 1'b1;
      end else if (clr_done_flag) begin
         flag_r <= 1'b0;
      end
   end

   // Wake pulse and timer clear pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_r <= 1'b0;
         tclr_r <= 1'b0;
      end else begin
         wake_r <= conv_done && sleep && adcc_is_rc(sel_r) && conversion_irq_enable;
         tclr_r <= special;
      end
   end

   assign converter_on = on_r;
   assign go_done = go_r;
   assign conversion_clock_select = sel_r;
   assign conversion_result = result_r;
   assign conversion_done_flag = flag_r;
   assign wake_request = wake_r;
   assign timer_clear = tclr_r;
   assign converter_powered = (st_r != ST_OFF) && (st_r != ST_PWRDN);
   assign sample_connect = (st_r == ST_ACQ);

   // Checker helpers: half periods seen in conversion and in hold
   logic [4:0] conv_cnt_r;
   logic [4:0] hold_cnt_r;
   always_ff @(posedge clk) begin
      if (rst || (st_r != ST_CONV)) begin
         conv_cnt_r <= 5'h00;
      end else if (half_tick) begin
         conv_cnt_r <= conv_cnt_r + 5'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || (st_r != ST_HOLD)) begin
         hold_cnt_r <= 5'h00;
      end else if (half_tick) begin
         hold_cnt_r <= hold_cnt_r + 5'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_abort;
      abort_req && !off_req && !osc_sleep_abort;
   endsequence
   sequence s_hold_disconnected;
      (st_r == ST_HOLD) && !sample_connect && !go_done;
   endsequence

   property p_abort_result;
      (abort_req && !wr_result) |=> (conversion_result == $past(conversion_result));
   endproperty
   a_abort_result: assert property (p_abort_result) else $error("result changed on abort");

   property p_abort_wait;
      s_abort |=> s_hold_disconnected;
   endproperty
   a_abort_wait: assert property (p_abort_wait) else $error("abort did not enter hold");

   property p_hold_len;
      ((st_r == ST_HOLD) ##1 (st_r == ST_ACQ)) |-> ($past(hold_cnt_r) == HOLD_HALVES - 5'h01);
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold not two bit periods");

   property p_done_go;
      (conv_done && !go_set) |=> !go_done && (conversion_result == $past(sar_bits));
   endproperty
   a_done_go: assert property (p_done_go) else $error("completion did not clear go or load result");

   property p_done_flag;
      conv_done |=> conversion_done_flag;
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag not set");

   property p_conv_len;
      conv_done |-> (conv_cnt_r == CONV_HALVES - 5'h01);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion not 9.5 bit periods");

   property p_rc_delay;
      ((st_r == ST_ACQ) && go_r && adcc_is_rc(sel_r) && on_r && !wr_ctrl)
         |=> (st_r == ST_RCWAIT)[*4] ##1 (st_r == ST_CONV);
   endproperty
   a_rc_delay: assert property (p_rc_delay) else $error("rc start delay wrong");

   property p_sel_lock;
      (adcc_busy(st_r) && adcc_is_rc(sel_r)) |=> adcc_is_rc(conversion_clock_select);
   endproperty
   a_sel_lock: assert property (p_sel_lock) else $error("select left rc while busy");

   property p_wake;
      (conv_done && sleep && adcc_is_rc(sel_r) && conversion_irq_enable) |=> wake_request ##1 !wake_request;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse");

   property p_rc_pwrdn;
      (conv_done && sleep && !conversion_irq_enable) |=> !converter_powered && converter_on;
   endproperty
   a_rc_pwrdn: assert property (p_rc_pwrdn) else $error("no power down after sleep completion");

   property p_osc_sleep;
      (osc_sleep_abort && !wr_ctrl) |=> !converter_powered && converter_on && !go_done;
   endproperty
   a_osc_sleep: assert property (p_osc_sleep) else $error("sleep did not abort");

   property p_trig_on;
      (special && on_r && !wr_ctrl && !osc_sleep_abort) |=> go_done && timer_clear;
   endproperty
   a_trig_on: assert property (p_trig_on) else $error("trigger did not start");

   property p_trig_off;
      (special && !on_r && !wr_ctrl) |=> timer_clear && !go_done;
   endproperty
   a_trig_off: assert property (p_trig_off) else $error("trigger wrong while off");

   property p_go_busy;
      adcc_busy(st_r) |-> go_done;
   endproperty
   a_go_busy: assert property (p_go_busy) else $error("go low during conversion");
endmodule

// *** adcc_analog_model.sv ***
// Behavioural analog front end: ideal comparator and free-running RC clock
`timescale 1ns/1ps
module adcc_analog_model
   import adcc_pkg::*;
#(
   parameter int RC_HALF = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [RESULT_W-1:0] level,
   input wire logic [RESULT_W-1:0] sar_trial,
   output logic cmp_in,
   output logic rc_half_tick
);
   int cnt;
   // Ideal comparator, so every completed 8-bit conversion result equals the level
   assign cmp_in = (level >= sar_trial);
   // RC source ticks regardless of the system clock select
   always_ff @(posedge clk) begin
      if (rst || cnt == RC_HALF - 1) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
      rc_half_tick <= !rst && (cnt == RC_HALF - 1);
   end
endmodule

// *** adc_conversion_control_bench.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_conversion_control_bench;
   import adcc_pkg::*;
   localparam int RC_H = 20;
   logic clk = 1'b0, rst = 1'b1, wr_ctrl = 1'b0, wr_on = 1'b0, wr_go = 1'b0;
   logic wr_result = 1'b0, clr_done_flag = 1'b0, irq_en = 1'b0, sleep = 1'b0, compare_event = 1'b0;
   logic [1:0] wr_clk_sel = 2'h0;
   logic [3:0] compare_mode_select = 4'h0;
   logic [7:0] wr_result_data = 8'h00, level = 8'h00;
   logic cmp_in, rc_half_tick, converter_on, go_done, done_flag, wake_request, timer_clear;
   logic converter_powered, sample_connect;
   logic [1:0] clk_sel_q;
   logic [7:0] conversion_result, sar_trial;
   int n_errors = 0, checked = 0, cycles = 0;

   adcc_ctrl dut (.clk(clk), .rst(rst), .wr_ctrl(wr_ctrl), .wr_on(wr_on), .wr_go(wr_go),
      .wr_clk_sel(wr_clk_sel), .wr_result(wr_result), .wr_result_data(wr_result_data),
      .clr_done_flag(clr_done_flag), .conversion_irq_enable(irq_en), .sleep(sleep),
      .compare_mode_select(compare_mode_select), .compare_event(compare_event),
      .rc_half_tick(rc_half_tick), .cmp_in(cmp_in), .converter_on(converter_on), .go_done(go_done),
      .conversion_clock_select(clk_sel_q), .conversion_result(conversion_result),
      .conversion_done_flag(done_flag), .wake_request(wake_request), .timer_clear(timer_clear),
      .converter_powered(converter_powered), .sample_connect(sample_connect), .sar_trial(sar_trial));
   adcc_analog_model #(.RC_HALF(RC_H)) model (.clk(clk), .rst(rst), .level(level),
      .sar_trial(sar_trial), .cmp_in(cmp_in), .rc_half_tick(rc_half_tick));

   // 100 ns period
   initial begin
      forever #50 clk = ~clk;
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic in_range(input string what, input int n, input int lo, input int hi);
      check(what, 16'(n), (n >= lo && n <= hi) ? 16'(n) : 16'(lo));
   endtask

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic ctrl(input logic on, input logic go, input logic [1:0] sel);
      @(negedge clk);
      wr_ctrl = 1'b1;
      wr_on = on;
      wr_go = go;
      wr_clk_sel = sel;
      @(negedge clk);
      wr_ctrl = 1'b0;
   endtask

   // Counts falling edges while the signal holds a value, bounded
   task automatic hold_count(ref logic s, input logic v, output int n);
      n = 0;
      while (s === v && n < 2000) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Switch on, acquire, then start in a later write
   task automatic arm(input logic [1:0] sel, input logic [7:0] v);
      int n;
      level = v;
      ctrl(1'b1, 1'b0, sel);
      hold_count(sample_connect, 1'b0, n);
      repeat (4) @(negedge clk);
      pulse(clr_done_flag);
      ctrl(1'b1, 1'b1, sel);
      hold_count(go_done, 1'b0, n);
   endtask

   task automatic convert(input logic [1:0] sel, input logic [7:0] v);
      int n;
      int h;
      h = (sel == 2'h0) ? 1 : (sel == 2'h1) ? 4 : 16;
      arm(sel, v);
      hold_count(go_done, 1'b1, n);
      in_range("conversion length", n, 19 * h + 1, 19 * h + 3);
      check("result", conversion_result, v);
      check("done flag", done_flag, 1'b1);
      hold_count(sample_connect, 1'b0, n);
      in_range("hold after completion", n, 4 * h - 1, 4 * h + 2);
   endtask

   task automatic abort_run;
      int n;
      wr_result_data = 8'h5A;
      pulse(wr_result);
      arm(2'h1, 8'hC3);
      repeat (20) @(negedge clk);
      check("go mid conversion", go_done, 1'b1);
      ctrl(1'b1, 1'b0, 2'h1);
      @(negedge clk);
      check("go after abort", go_done, 1'b0);
      check("kept result", conversion_result, 8'h5A);
      check("no done flag", done_flag, 1'b0);
      hold_count(sample_connect, 1'b0, n);
      // Two 8Tosc bit periods are 16 clocks, less the cycles spent in the write and the check
      in_range("wait after abort", n, 4 * 4 - 4, 4 * 4);
   endtask

   task automatic clock_switch;
      int n;
      arm(2'h2, 8'h96);
      repeat (40) @(negedge clk);
      ctrl(1'b1, 1'b1, 2'h3);
      check("select kept", clk_sel_q, 2'h2);
      ctrl(1'b1, 1'b1, 2'h0);
      check("select switched", clk_sel_q, 2'h0);
      hold_count(go_done, 1'b1, n);
      in_range("shortened conversion", n, 10, 40);
      hold_count(sample_connect, 1'b0, n);
   endtask

   task automatic rc_sleep(input logic irq);
      int n;
      logic woke;
      logic [7:0] v;
      // Distinct levels per call so a missed store cannot hide behind the old result
      v = irq ? 8'h3C : 8'hC3;
      irq_en = irq;
      arm(2'h3, v);
      sleep = 1'b1;
      hold_count(go_done, 1'b1, n);
      in_range("rc conversion length", n, 19 * RC_H - RC_H, 19 * RC_H + 25);
      check("rc result", conversion_result, v);
      woke = 1'b0;
      repeat (3) begin
         woke = woke | (wake_request === 1'b1);
         @(negedge clk);
      end
      check("wake", woke, irq);
      check("powered", converter_powered, irq);
      check("on bit", converter_on, 1'b1);
      sleep = 1'b0;
      irq_en = 1'b0;
      hold_count(sample_connect, 1'b0, n);
   endtask

   task automatic sleep_abort;
      int n;
      arm(2'h1, 8'hF0);
      repeat (30) @(negedge clk);
      sleep = 1'b1;
      repeat (2) @(negedge clk);
      check("powered in sleep", converter_powered, 1'b0);
      check("go in sleep", go_done, 1'b0);
      check("on in sleep", converter_on, 1'b1);
      check("result in sleep", conversion_result, 8'hC3);
      sleep = 1'b0;
      hold_count(sample_connect, 1'b0, n);
   endtask

   task automatic trigger(input logic on, input logic [3:0] mode);
      int n;
      logic cleared;
      logic started;
      level = 8'h42;
      ctrl(on, 1'b0, 2'h1);
      if (on) begin
         hold_count(sample_connect, 1'b0, n);
      end
      compare_mode_select = mode;
      pulse(compare_event);
      cleared = timer_clear;
      started = go_done;
      @(negedge clk);
      cleared = cleared | timer_clear;
      started = started | go_done;
      check("timer clear", cleared, mode == 4'hB);
      check("trigger start", started, on && mode == 4'hB);
      hold_count(go_done, 1'b1, n);
      if (on) begin
         hold_count(sample_connect, 1'b0, n);
      end
   endtask

   task automatic mid_reset;
      logic [7:0] prev;
      arm(2'h1, 8'h18);
      repeat (20) @(negedge clk);
      prev = conversion_result;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check("on after reset", converter_on, 1'b0);
      check("go after reset", go_done, 1'b0);
      check("select after reset", clk_sel_q, 2'h0);
      check("result after reset", conversion_result, prev);
   endtask

   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check("result at power-up", conversion_result, 8'hXX);
      check("on at reset", converter_on, 1'b0);
      check("powered at reset", converter_powered, 1'b0);
      convert(2'h0, 8'hA5);
      convert(2'h1, 8'h01);
      convert(2'h2, 8'hFF);
      abort_run();
      clock_switch();
      rc_sleep(1'b1);
      rc_sleep(1'b0);
      sleep_abort();
      trigger(1'b1, 4'hB);
      trigger(1'b0, 4'hB);
      trigger(1'b1, 4'hA);
      mid_reset();
      final_report();
   end
endmodule
